// ### core/low_voltage_reset_and_flags.sv
// Low-voltage reset, reset-cause flags, self-checking control codes and APB registers
//
// The address map and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module low_voltage_reset_and_flags
(
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        supply_low_raw,
    input  wire logic        slow_osc_raw,
    input  wire logic        low_power_mode,
    input  wire logic        wdt_timeout,
    input  wire logic        wdt_reg_reset_req,
    output logic      [7:0]  threshold_code,
    output logic             lvr_enable,
    output logic             reset_pin_select,
    output logic             device_reset,
    output logic             pc_sp_clear,
    output logic             timeout_status_flag,
    output logic             power_down_flag,
    output logic             irq
);
    import lvr_pkg::*;

    logic                  low_meta_ff;
    logic                  low_sync_ff;
    logic                  osc_meta_ff;
    logic                  osc_sync_ff;
    logic                  osc_prev_ff;
    logic [7:0]            filter_cnt_ff;
    logic [1:0]            filter_time_code_ff;
    logic [7:0]            rstctl_ff;
    logic [7:0]            prog_ctrl_ff;
    logic                  iap_req_ff;
    logic [15:0]           soft_cnt_ff;
    cause_flags_t          cause_ff;
    logic                  lvr_active_ff;
    logic [NUM_EVENTS-1:0] irq_status_ff;
    logic [NUM_EVENTS-1:0] irq_mask_ff;
    logic                  slow_edge;
    logic                  lvr_active;
    logic [7:0]            filter_target;
    logic                  accept;
    logic                  thr_invalid;
    logic                  rstctl_invalid;
    logic                  lvr_trip;
    logic                  soft_trip;
    logic                  wdt_run_trip;
    logic                  wdt_sleep_hit;
    logic                  restore_trip;
    logic                  nxt_device_reset;
    logic                  wr_access;
    logic                  rd_setup;
    logic [NUM_EVENTS-1:0] events;

    // Known threshold code or disable code; everything else is corrupt
    function automatic logic code_known(input logic [7:0] code);
        return (code == THR_1V70) || (code == THR_1V90) || (code == THR_2V55) ||
               (code == THR_3V15) || (code == THR_3V80) || (code == THR_DISABLE);
    endfunction : code_known

    // Word offset lies inside the register map
    function automatic logic addr_mapped(input logic [11:0] addr);
        return (addr[11:2] <= OFF_LIVE_STATE[11:2]);
    endfunction : addr_mapped

    // Edge count for each filter time code
    function automatic logic [7:0] filter_edges(input logic [1:0] code);
        unique case (code)
            2'h0: return FILTER_N_00;
            2'h1: return FILTER_N_01;
            2'h2: return FILTER_N_10;
            2'h3: return FILTER_N_11;
        endcase
    endfunction : filter_edges

    // Asynchronous comparator and oscillator pins, two flip-flops each
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            low_meta_ff <= 1'b0;
            low_sync_ff <= 1'b0;
            osc_meta_ff <= 1'b0;
            osc_sync_ff <= 1'b0;
            osc_prev_ff <= 1'b0;
        end
        else
        begin
            low_meta_ff <= supply_low_raw;
            low_sync_ff <= low_meta_ff;
            osc_meta_ff <= slow_osc_raw;
            osc_sync_ff <= osc_meta_ff;
            osc_prev_ff <= osc_sync_ff;
        end
    end

    // Trip conditions; a reset in progress blocks new ones for a cycle
    always_comb
    begin
        slow_edge      = osc_sync_ff & ~osc_prev_ff;
        accept         = ~device_reset;
        thr_invalid    = ~code_known(threshold_code);
        rstctl_invalid = (rstctl_ff != RSTCTL_IO_PIN) &&
                         (rstctl_ff != RSTCTL_RESET_PIN);
        lvr_active     = code_known(threshold_code) && (threshold_code != THR_DISABLE) &&
                         ~low_power_mode;
        filter_target  = filter_edges(filter_time_code_ff);
        lvr_trip       = accept & lvr_active & low_sync_ff &
                         (filter_cnt_ff == filter_target);
        soft_trip      = accept & (thr_invalid | rstctl_invalid) &
                         (soft_cnt_ff == 16'(SOFT_RESET_CYCLES - 1));
        wdt_run_trip   = accept & wdt_timeout & ~low_power_mode;
        wdt_sleep_hit  = accept & wdt_timeout & low_power_mode;
        restore_trip   = soft_trip | wdt_run_trip | (accept & iap_req_ff) |
                         (accept & wdt_reg_reset_req);
        nxt_device_reset = lvr_trip | restore_trip;
        wr_access      = psel & penable & pready & pwrite;
        rd_setup       = psel & ~penable & ~pwrite;
    end

    // Filter counter: stays at zero unless low is seen while enabled;
    // a shorter filter code chosen mid-count clamps it, so the trip still comes
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            filter_cnt_ff <= 8'h00;
        else if (device_reset || !lvr_active || !low_sync_ff)
            filter_cnt_ff <= 8'h00;
        else if (filter_cnt_ff > filter_target)
            filter_cnt_ff <= filter_target;
        else if (slow_edge && filter_cnt_ff < filter_target)
            filter_cnt_ff <= filter_cnt_ff + 8'h01;
    end

    // Soft-reset delay runs while either control code is corrupt
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            soft_cnt_ff <= 16'h0000;
        else if (device_reset || !(thr_invalid || rstctl_invalid))
            soft_cnt_ff <= 16'h0000;
        else if (soft_cnt_ff != 16'(SOFT_RESET_CYCLES - 1))
            soft_cnt_ff <= soft_cnt_ff + 16'h0001;
    end

    // Threshold select: a low-voltage reset alone leaves it untouched
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            threshold_code <= THR_POR;
        else if (restore_trip)
            threshold_code <= THR_POR;
        else if (wr_access && paddr[11:2] == OFF_THRESHOLD[11:2])
            threshold_code <= pwdata[7:0];
    end

    // Filter time select, reset function control, programming control
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            filter_time_code_ff <= FILTER_POR;
            rstctl_ff           <= RSTCTL_POR;
            prog_ctrl_ff        <= 8'h00;
            iap_req_ff          <= 1'b0;
        end
        else
        begin
            iap_req_ff <= wr_access && (paddr[11:2] == OFF_PROG_CTRL_ONE[11:2]) &&
                          (pwdata[7:0] == PROG_RESET_KEY);
            if (nxt_device_reset)
            begin
                rstctl_ff    <= RSTCTL_POR;
                prog_ctrl_ff <= 8'h00;
            end
            else if (wr_access)
            begin
                if (paddr[11:2] == OFF_FILTER_TIME[11:2])
                    filter_time_code_ff <= pwdata[1:0];
                if (paddr[11:2] == OFF_RESET_FUNC[11:2])
                    rstctl_ff <= pwdata[7:0];
                if (paddr[11:2] == OFF_PROG_CTRL_ONE[11:2])
                    prog_ctrl_ff <= pwdata[7:0];
            end
        end
    end

    // Sticky cause flags survive device resets; hardware set wins over write
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            cause_ff <= '0;
        else
        begin
            if (wr_access && paddr[11:2] == OFF_CAUSE_FLAGS[11:2])
                cause_ff <= pwdata[3:0];
            if (soft_trip && rstctl_invalid)
                cause_ff.rstctl <= 1'b1;
            if (lvr_trip)
                cause_ff.lvr <= 1'b1;
            if (soft_trip && thr_invalid)
                cause_ff.thr_reg <= 1'b1;
            if (accept && wdt_reg_reset_req)
                cause_ff.wdt_reg <= 1'b1;
        end
    end

    // Time-out and power-down flags, writable by software, set wins
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            timeout_status_flag <= 1'b0;
            power_down_flag     <= 1'b0;
        end
        else
        begin
            if (wr_access && paddr[11:2] == OFF_CPU_STATUS[11:2])
            begin
                timeout_status_flag <= pwdata[0];
                power_down_flag     <= pwdata[1];
            end
            if (wdt_run_trip || wdt_sleep_hit)
                timeout_status_flag <= 1'b1;
            if (wdt_sleep_hit)
                power_down_flag <= 1'b1;
        end
    end

    // Reset pulses and pin-facing levels, all registered
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            device_reset     <= 1'b0;
            pc_sp_clear      <= 1'b0;
            lvr_active_ff    <= 1'b0;
            reset_pin_select <= 1'b0;
            lvr_enable       <= 1'b0;
        end
        else
        begin
            device_reset     <= nxt_device_reset;
            pc_sp_clear      <= wdt_sleep_hit;
            lvr_active_ff    <= lvr_active;
            reset_pin_select <= (rstctl_ff == RSTCTL_RESET_PIN);
            lvr_enable       <= lvr_active;
        end
    end

    // Interrupt events: one per kind of reset except the watchdog register request, plus the low-power time-out
    assign events = {wdt_sleep_hit, wdt_run_trip, accept & iap_req_ff,
                     soft_trip & rstctl_invalid, soft_trip & thr_invalid, lvr_trip};

    // Write-one-to-clear status; an event in the clearing cycle is kept
    genvar gi;
    generate
        for (gi = 0; gi < NUM_EVENTS; gi++)
        begin : g_irq_bit
            always_ff @(posedge mclk or posedge rst)
            begin
                if (rst)
                    irq_status_ff[gi] <= 1'b0;
                else if (events[gi])
                    irq_status_ff[gi] <= 1'b1;
                else if (wr_access && paddr[11:2] == OFF_IRQ_STATUS[11:2] && pwdata[gi])
                    irq_status_ff[gi] <= 1'b0;
            end
        end
    endgenerate

    // Mask and interrupt line; one cycle behind the status bits
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            irq_mask_ff <= '0;
            irq         <= 1'b0;
        end
        else
        begin
            if (wr_access && paddr[11:2] == OFF_IRQ_MASK[11:2])
                irq_mask_ff <= pwdata[NUM_EVENTS-1:0];
            irq <= |(irq_status_ff & irq_mask_ff);
        end
    end

    // APB answer: data latched in setup, pready high in the first access cycle
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~addr_mapped(paddr);
            if (rd_setup)
            begin
                prdata <= 32'h0000_0000;
                unique case (paddr[11:2])
                    OFF_CAUSE_FLAGS[11:2]:   prdata[3:0] <= cause_ff;
                    OFF_THRESHOLD[11:2]:     prdata[7:0] <= threshold_code;
                    OFF_FILTER_TIME[11:2]:   prdata[1:0] <= filter_time_code_ff;
                    OFF_RESET_FUNC[11:2]:    prdata[7:0] <= rstctl_ff;
                    OFF_PROG_CTRL_ONE[11:2]: prdata[7:0] <= prog_ctrl_ff;
                    OFF_CPU_STATUS[11:2]:    prdata[1:0] <= {power_down_flag,
                                                             timeout_status_flag};
                    OFF_IRQ_STATUS[11:2]:    prdata[NUM_EVENTS-1:0] <= irq_status_ff;
                    OFF_IRQ_MASK[11:2]:      prdata[NUM_EVENTS-1:0] <= irq_mask_ff;
                    OFF_LIVE_STATE[11:2]:    prdata[9:0] <= {filter_cnt_ff,
                                                             low_sync_ff, lvr_active_ff};
                    default:                 prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    sequence s_iap_write;
        wr_access && paddr[11:2] == OFF_PROG_CTRL_ONE[11:2] && pwdata[7:0] == PROG_RESET_KEY;
    endsequence

    sequence s_lvr_qualified;
        accept && lvr_active && low_sync_ff ##0 filter_cnt_ff == filter_target;
    endsequence

    a_rstctl_soft_reset_flag_sticky_set: assert property (soft_trip && rstctl_invalid |=>
        cause_ff.rstctl && device_reset && rstctl_ff == RSTCTL_POR)
        else $error("control-register soft reset did not set its flag");
    a_cause_upper_zero: assert property (rd_setup &&
        paddr[11:2] == OFF_CAUSE_FLAGS[11:2] |=> prdata[31:4] == 28'h0)
        else $error("cause register upper bits not zero");
    a_lvr_flag_reset: assert property (s_lvr_qualified |=>
        device_reset && cause_ff.lvr)
        else $error("qualified low voltage did not reset and flag");
    a_short_low_ignored: assert property ($fell(low_sync_ff) |->
        !lvr_trip ##1 filter_cnt_ff == 8'h00)
        else $error("filter did not clear when low ended");
    a_low_power_off: assert property (low_power_mode |=>
        filter_cnt_ff == 8'h00 && !lvr_trip)
        else $error("low-voltage reset active in low power");
    a_bad_code_restore: assert property (soft_trip && thr_invalid |=>
        threshold_code == THR_POR && cause_ff.thr_reg && device_reset)
        else $error("invalid threshold code not restored or flagged");
    a_lvr_keeps_code: assert property (lvr_trip && !restore_trip && !wr_access |=>
        threshold_code == $past(threshold_code))
        else $error("low-voltage reset changed threshold code");
    a_filter_bound: assert property (filter_cnt_ff <= filter_target ||
        $changed(filter_time_code_ff) || $past(filter_time_code_ff) != filter_time_code_ff)
        else $error("filter counter passed its target");
    a_iap_reset_seq: assert property (s_iap_write ##1 accept |=> device_reset)
        else $error("programming key did not reset device");
    a_wdt_run_reset: assert property (wdt_run_trip |=>
        device_reset && timeout_status_flag && !pc_sp_clear)
        else $error("watchdog run-mode time-out handled wrongly");
    a_wdt_sleep_pcsp: assert property (wdt_sleep_hit && !restore_trip && !lvr_trip |=>
        pc_sp_clear && timeout_status_flag && power_down_flag && !device_reset)
        else $error("watchdog low-power time-out handled wrongly");
endmodule : low_voltage_reset_and_flags
`default_nettype wire

// ### shared/lvr_pkg.sv
// Package: register map, field layout, reset values and timing for the reset-source block
package lvr_pkg;
    // Register byte offsets (one aligned 32-bit word each)
    localparam logic [11:0] OFF_CAUSE_FLAGS   = 12'h000;
    localparam logic [11:0] OFF_THRESHOLD     = 12'h004;
    localparam logic [11:0] OFF_FILTER_TIME   = 12'h008;
    localparam logic [11:0] OFF_RESET_FUNC    = 12'h00c;
    localparam logic [11:0] OFF_PROG_CTRL_ONE = 12'h010;
    localparam logic [11:0] OFF_CPU_STATUS    = 12'h014;
    localparam logic [11:0] OFF_IRQ_STATUS    = 12'h018;
    localparam logic [11:0] OFF_IRQ_MASK      = 12'h01c;
    localparam logic [11:0] OFF_LIVE_STATE    = 12'h020;

    // Threshold select codes
    localparam logic [7:0] THR_1V70    = 8'h66;
    localparam logic [7:0] THR_1V90    = 8'h55;
    localparam logic [7:0] THR_2V55    = 8'h33;
    localparam logic [7:0] THR_3V15    = 8'h99;
    localparam logic [7:0] THR_3V80    = 8'haa;
    localparam logic [7:0] THR_DISABLE = 8'hf0;
    localparam logic [7:0] THR_POR     = 8'h66;

    // Reset function control codes
    localparam logic [7:0] RSTCTL_IO_PIN    = 8'h55;
    localparam logic [7:0] RSTCTL_RESET_PIN = 8'haa;
    localparam logic [7:0] RSTCTL_POR       = 8'h55;

    // Filter time select and slow-oscillator edge counts
    localparam logic [1:0] FILTER_POR  = 2'h1;
    localparam logic [7:0] FILTER_N_00 = 8'h08;
    localparam logic [7:0] FILTER_N_01 = 8'h20;
    localparam logic [7:0] FILTER_N_10 = 8'h40;
    localparam logic [7:0] FILTER_N_11 = 8'h80;

    // Programming control value that resets the whole device
    localparam logic [7:0] PROG_RESET_KEY = 8'h55;

    // Cause flag bit positions and interrupt event count
    localparam int FLAG_WDT_REG = 0;
    localparam int FLAG_THR_REG = 1;
    localparam int FLAG_LVR     = 2;
    localparam int FLAG_RSTCTL  = 3;
    localparam int NUM_EVENTS   = 6;

    // Timing: clock and software-reset delay
    localparam int CLK_PERIOD_NS       = 40;
    localparam int SOFT_RESET_DELAY_NS = 16000;
    localparam int SOFT_RESET_CYCLES   =
        (SOFT_RESET_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Sticky reset cause flags, bit 3 down to bit 0
    typedef struct packed {
        logic rstctl;
        logic lvr;
        logic thr_reg;
        logic wdt_reg;
    } cause_flags_t;
endpackage : lvr_pkg

// ### tb/low_voltage_reset_and_flags_test.sv
// Self-checking bench: reset causes, low-voltage filter, soft resets, APB registers
`timescale 1ns/1ps
`default_nettype none
module low_voltage_reset_and_flags_test;
    import lvr_pkg::*;
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic        supply_low_raw = 1'b0;
    logic        slow_osc_raw = 1'b0;
    logic        low_power_mode = 1'b0;
    logic        wdt_timeout = 1'b0;
    logic        wdt_reg_reset_req = 1'b0;
    logic [31:0] prdata;
    logic        pready, pslverr, lvr_enable, reset_pin_select, device_reset;
    logic        pc_sp_clear, timeout_status_flag, power_down_flag, irq;
    logic [7:0]  threshold_code;
    logic [31:0] q;
    logic [31:0] seed = 32'h4de9;
    logic [7:0]  code;
    logic        last_err;
    logic [2:0]  osc_div = 3'h0;
    int          err_total = 0;
    int          cmp_count = 0;
    int          pc_cnt = 0;

    low_voltage_reset_and_flags low_voltage_reset_and_flags_inst (
        .mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .supply_low_raw(supply_low_raw), .slow_osc_raw(slow_osc_raw),
        .low_power_mode(low_power_mode), .wdt_timeout(wdt_timeout),
        .wdt_reg_reset_req(wdt_reg_reset_req), .threshold_code(threshold_code),
        .lvr_enable(lvr_enable), .reset_pin_select(reset_pin_select),
        .device_reset(device_reset), .pc_sp_clear(pc_sp_clear),
        .timeout_status_flag(timeout_status_flag), .power_down_flag(power_down_flag),
        .irq(irq));

    always #20 mclk = ~mclk;

    // Slow oscillator stand-in, period of ten clocks; free-running like the real one
    always @(posedge mclk)
    begin
        osc_div <= (osc_div == 3'h4) ? 3'h0 : osc_div + 3'h1;
        slow_osc_raw <= (osc_div == 3'h4) ? ~slow_osc_raw : slow_osc_raw;
        pc_cnt <= pc_cnt + ((pc_sp_clear === 1'b1) ? 1 : 0);
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs

    // Expected filter length in slow edges for each filter code
    function automatic int filt_n(input int fc);
        return (fc == 0) ? 8 : (16 << fc);
    endfunction : filt_n

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : conclude

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        cmp_count++;
        if (seen !== exp)
        begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        q = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Idle edge, so a following call never drives psel twice in one step
        @(posedge mclk);
        if (n >= 20)
        begin
            err_total++;
            conclude();
        end
    endtask : apb

    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string what);
        apb(1'b0, a, 32'h0);
        chk(q, exp, what);
    endtask : rd

    // Bounded watch for a device reset pulse; a missing expected pulse ends the run
    task automatic wait_rst(input int lim, input logic exp, input string what);
        logic seen;
        seen = 1'b0;
        for (int n = 0; n < lim && !seen; n++)
        begin
            @(posedge mclk);
            seen = (device_reset === 1'b1);
        end
        chk({31'h0, seen}, {31'h0, exp}, what);
        if (exp && !seen)
            conclude();
    endtask : wait_rst

    initial
    begin
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        rd(OFF_CAUSE_FLAGS, 32'h0, "cause flags por");
        rd(OFF_THRESHOLD, 32'h66, "threshold por");
        chk({24'h0, threshold_code}, 32'h66, "threshold pin");
        rd(OFF_FILTER_TIME, 32'h1, "filter por");
        apb(1'b1, OFF_FILTER_TIME, 32'hff);
        rd(OFF_FILTER_TIME, 32'h3, "filter bits");
        rd(12'h040, 32'h0, "unmapped read");
        chk({31'h0, last_err}, 32'h1, "unmapped error");
        apb(1'b1, OFF_IRQ_MASK, 32'h3f);
        apb(1'b1, OFF_FILTER_TIME, 32'h0);
        apb(1'b1, OFF_THRESHOLD, {24'h0, THR_1V90});
        // Low pulse of three slow edges only, then low blocked by sleep and by disable
        supply_low_raw <= 1'b1;
        wait_rst(30, 1'b0, "short low");
        supply_low_raw <= 1'b0;
        wait_rst(150, 1'b0, "short low after");
        low_power_mode <= 1'b1;
        supply_low_raw <= 1'b1;
        wait_rst(200, 1'b0, "low in sleep");
        chk({31'h0, lvr_enable}, 32'h0, "lvr enable sleep");
        supply_low_raw <= 1'b0;
        low_power_mode <= 1'b0;
        apb(1'b1, OFF_THRESHOLD, {24'h0, THR_DISABLE});
        supply_low_raw <= 1'b1;
        wait_rst(200, 1'b0, "low disabled");
        chk({31'h0, lvr_enable}, 32'h0, "lvr enable disabled");
        supply_low_raw <= 1'b0;
        // Every filter code: no reset early, reset just after N slow edges
        for (int fc = 0; fc < 4; fc++)
        begin
            apb(1'b1, OFF_FILTER_TIME, 32'(fc));
            apb(1'b1, OFF_THRESHOLD, {24'h0, THR_1V90});
            supply_low_raw <= 1'b1;
            wait_rst(filt_n(fc) * 10 - 15, 1'b0, "filter early");
            chk({31'h0, lvr_enable}, 32'h1, "lvr enable on");
            wait_rst(40, 1'b1, "filter reset");
            supply_low_raw <= 1'b0;
            rd(OFF_CAUSE_FLAGS, 32'h4, "lvr flag");
            rd(OFF_THRESHOLD, {24'h0, THR_1V90}, "threshold kept");
            apb(1'b1, OFF_CAUSE_FLAGS, 32'h0);
        end
        rd(OFF_CAUSE_FLAGS, 32'h0, "lvr flag cleared");
        chk({31'h0, irq}, 32'h1, "irq raised");
        apb(1'b1, OFF_IRQ_MASK, 32'h0);
        repeat (2) @(posedge mclk);
        chk({31'h0, irq}, 32'h0, "irq masked");
        apb(1'b1, OFF_IRQ_STATUS, 32'h3f);
        rd(OFF_IRQ_STATUS, 32'h0, "irq status cleared");
        // Random invalid codes in threshold and reset-function registers
        for (int k = 0; k < 2; k++)
        begin
            do
            begin
                seed = xs(seed);
                code = seed[7:0];
            end
            while ((k == 0) ? (code inside {8'h66, 8'h55, 8'h33, 8'h99, 8'haa, 8'hf0})
                            : (code inside {8'h55, 8'haa}));
            apb(1'b1, (k == 0) ? OFF_THRESHOLD : OFF_RESET_FUNC, {24'h0, code});
            wait_rst(380, 1'b0, "soft early");
            wait_rst(40, 1'b1, "soft reset");
            rd(OFF_CAUSE_FLAGS, (k == 0) ? 32'h2 : 32'h8, "soft flag");
            chk({24'h0, threshold_code}, 32'h66, "threshold restored");
            apb(1'b1, OFF_CAUSE_FLAGS, 32'h0);
        end
        apb(1'b1, OFF_RESET_FUNC, {24'h0, RSTCTL_RESET_PIN});
        wait_rst(450, 1'b0, "reset pin code kept");
        chk({31'h0, reset_pin_select}, 32'h1, "reset pin select");
        apb(1'b1, OFF_PROG_CTRL_ONE, 32'h54);
        wait_rst(10, 1'b0, "prog other value");
        apb(1'b1, OFF_PROG_CTRL_ONE, {24'h0, PROG_RESET_KEY});
        wait_rst(5, 1'b1, "prog reset");
        // Watchdog time-out while running, then while asleep
        wdt_timeout <= 1'b1;
        @(posedge mclk);
        wdt_timeout <= 1'b0;
        wait_rst(3, 1'b1, "wdt run reset");
        chk({31'h0, timeout_status_flag}, 32'h1, "timeout flag");
        chk({31'h0, power_down_flag}, 32'h0, "power down run");
        low_power_mode <= 1'b1;
        wdt_timeout <= 1'b1;
        @(posedge mclk);
        wdt_timeout <= 1'b0;
        wait_rst(5, 1'b0, "wdt sleep no reset");
        chk(32'(pc_cnt), 32'h1, "pc sp clear");
        chk({31'h0, power_down_flag}, 32'h1, "power down flag");
        low_power_mode <= 1'b0;
        wdt_reg_reset_req <= 1'b1;
        @(posedge mclk);
        wdt_reg_reset_req <= 1'b0;
        wait_rst(3, 1'b1, "wdt reg reset");
        rd(OFF_CAUSE_FLAGS, 32'h1, "wdt reg flag");
        conclude();
    end
endmodule : low_voltage_reset_and_flags_test
`default_nettype wire
